// File: include/gdo_pkg.sv
// gdo_pkg: shared constants and state type for the door opener controller
// assumes a single scan clock; tick timing derived from the clock rate below
package gdo_pkg;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TICK_MS         = 100;
    // cycles per 0.1 s light-timer tick
    localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000) * TICK_MS;
    localparam int unsigned LIGHT_PRESET    = 1800;
    localparam int unsigned TICK_W          = 22;
    localparam int unsigned LIGHT_W         = 11;

    typedef enum logic [2:0] {
        DOOR_CLOSED_STATE,
        PRESS_TO_RAISE_STATE,
        RAISING_STATE,
        DOOR_OPEN_STATE,
        PRESS_TO_LOWER_STATE,
        LOWERING_STATE
    } gdo_state_t;

endpackage

// File: verilog/gdo_light_timer.sv
// gdo_light_timer: safety-light process with its three-minute tick timer
// assumes i_set is a one-cycle pulse from the door sequence
`timescale 1ns/100ps
module gdo_light_timer
    import gdo_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES,
    parameter int unsigned PRESET   = LIGHT_PRESET
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_set,
    output logic      o_lamp,
    output logic      o_done
);
    logic               active_ff;
    logic               nxt_active;
    logic [TICK_W-1:0]  tick_cnt_ff;
    logic [TICK_W-1:0]  nxt_tick_cnt;
    logic [LIGHT_W-1:0] light_cnt_ff;
    logic [LIGHT_W-1:0] nxt_light_cnt;
    logic               tick_en;
    logic               done;

    assign tick_en = active_ff && (tick_cnt_ff == TICK_W'(TICK_LEN - 1));    // RULE18
    assign done    = (light_cnt_ff == LIGHT_W'(PRESET));

    always_comb begin
        nxt_active    = active_ff;
        nxt_tick_cnt  = tick_cnt_ff;
        nxt_light_cnt = light_cnt_ff;
        if (active_ff) begin
            // re-set while active and not yet done does not restart the count
            nxt_tick_cnt = tick_en ? '0 : tick_cnt_ff + 1'b1;               // RULE11
            if (tick_en && !done) begin
                nxt_light_cnt = light_cnt_ff + 1'b1;                      // RULE11
            end
            // clear on the way out so the idle timer always reads zero
            if (done) begin
                nxt_active    = 1'b0;                                     // RULE12
                nxt_tick_cnt  = '0;                                       // RULE17
                nxt_light_cnt = '0;                                       // RULE17
            end
        end else begin
            nxt_tick_cnt  = '0;                                           // RULE17
            nxt_light_cnt = '0;                                           // RULE17
        end
        // a set in the done cycle wins, re-lighting the lamp
        if (i_set && (!active_ff || done)) begin
            nxt_active    = 1'b1;                                         // RULE10
            nxt_tick_cnt  = '0;
            nxt_light_cnt = '0;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            active_ff    <= 1'b0;                                         // RULE1
            tick_cnt_ff  <= '0;
            light_cnt_ff <= '0;
        end else begin
            active_ff    <= nxt_active;
            tick_cnt_ff  <= nxt_tick_cnt;
            light_cnt_ff <= nxt_light_cnt;
        end
    end

    assign o_lamp = active_ff;                                            // RULE11
    assign o_done = active_ff && done;

    chk_light_idle_clear: assert property (@(posedge i_clk) disable iff (i_reset) // RULE17
        !active_ff |-> (light_cnt_ff == '0 && tick_cnt_ff == '0))
        else $error("light timer not clear while idle");

    chk_done_ends_light: assert property (@(posedge i_clk) disable iff (i_reset) // RULE12
        (o_done && !i_set) |=> !o_lamp)
        else $error("lamp stayed on after timer done");

    chk_set_lights_lamp: assert property (@(posedge i_clk) disable iff (i_reset) // RULE10
        i_set |=> o_lamp)
        else $error("set did not light lamp");

    chk_no_restart: assert property (@(posedge i_clk) disable iff (i_reset) // RULE17
        (active_ff && !done && i_set) |=> (light_cnt_ff >= $past(light_cnt_ff)))
        else $error("re-set restarted light count");
endmodule

// File: verilog/gdo_door_ctrl.sv
// gdo_door_ctrl: single-button door opener sequence with safety light
// assumes all inputs synchronous to I_CLK; one clock edge equals one scan
//
// Contract
// RULE1: reset enters closed state, light off
// RULE2: closed: motors off, wait for press
// RULE3: press-to-raise: release starts raising and light
// RULE4: raise/lower commands track their states exactly
// RULE5: up limit ends raising into open
// RULE6: open: press then release starts lowering
// RULE7: down limit without obstruction closes door
// RULE8: obstruction while lowering goes press-to-raise
// RULE9: obstruction wins over down limit
// RULE10: light set independently, door unaffected
// RULE11: lamp on while light active, 1800 ticks
// RULE12: timer done turns light off
// RULE13: door sequence runs independent of light
// RULE14: obstruction held while object present
// RULE15: state outputs drop when state left
// RULE16: limit inputs only at end of travel
// RULE17: light timer cleared when idle, no restart
// RULE18: one evaluation per clock, tick enable
// RULE19: exactly one door state active
`timescale 1ns/100ps
module gdo_door_ctrl
    import gdo_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES,
    parameter int unsigned PRESET   = LIGHT_PRESET
) (
    input  wire logic I_CLK,
    input  wire logic I_RESET,
    input  wire logic I_DOOR_BUTTON_IN,
    input  wire logic I_UP_LIMIT_IN,
    input  wire logic I_DOWN_LIMIT_IN,
    input  wire logic I_OBSTRUCTION_IN,
    output logic      O_RAISE_CMD_OUT,
    output logic      O_LOWER_CMD_OUT,
    output logic      O_LAMP_OUT,
    output logic      O_LIGHT_TIMER_DONE
);
    import gdo_pkg::*;

    gdo_state_t state_ff;
    gdo_state_t nxt_state;
    logic       light_set;
    logic       nxt_raise;
    logic       nxt_lower;
    logic       raise_ff;
    logic       lower_ff;

    // one transition per scan; enum encodes a single active state
    always_comb begin                                                     // RULE19
        nxt_state = state_ff;
        light_set = 1'b0;
        unique case (state_ff)
            DOOR_CLOSED_STATE: begin
                if (I_DOOR_BUTTON_IN) begin
                    nxt_state = PRESS_TO_RAISE_STATE;                     // RULE2
                end
            end
            PRESS_TO_RAISE_STATE: begin
                if (!I_DOOR_BUTTON_IN) begin
                    nxt_state = RAISING_STATE;                            // RULE3
                    light_set = 1'b1;                                     // RULE10
                end
            end
            RAISING_STATE: begin
                if (I_UP_LIMIT_IN) begin
                    nxt_state = DOOR_OPEN_STATE;                          // RULE5
                end
            end
            DOOR_OPEN_STATE: begin
                if (I_DOOR_BUTTON_IN) begin
                    nxt_state = PRESS_TO_LOWER_STATE;                     // RULE6
                end
            end
            PRESS_TO_LOWER_STATE: begin
                if (!I_DOOR_BUTTON_IN) begin
                    nxt_state = LOWERING_STATE;                           // RULE6
                    light_set = 1'b1;                                     // RULE10
                end
            end
            LOWERING_STATE: begin
                // obstruction has priority; held by the sensor while blocked
                if (I_OBSTRUCTION_IN) begin
                    nxt_state = PRESS_TO_RAISE_STATE;                     // RULE8 RULE9 RULE14
                end else if (I_DOWN_LIMIT_IN) begin
                    nxt_state = DOOR_CLOSED_STATE;                        // RULE7
                end
            end
            default: begin
                nxt_state = DOOR_CLOSED_STATE;
            end
        endcase
        nxt_raise = (nxt_state == RAISING_STATE);                         // RULE4 RULE15
        nxt_lower = (nxt_state == LOWERING_STATE);                        // RULE4 RULE15
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_ff <= DOOR_CLOSED_STATE;                                // RULE1
            raise_ff <= 1'b0;
            lower_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;                                        // RULE18
            raise_ff <= nxt_raise;
            lower_ff <= nxt_lower;
        end
    end

    assign O_RAISE_CMD_OUT = raise_ff;
    assign O_LOWER_CMD_OUT = lower_ff;

    // light process runs beside the door sequence and never alters it
    gdo_light_timer #(
        .TICK_LEN (TICK_LEN),
        .PRESET   (PRESET)
    ) u_light (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .i_set   (light_set),                                             // RULE13
        .o_lamp  (O_LAMP_OUT),
        .o_done  (O_LIGHT_TIMER_DONE)
    );

    sequence s_lowering_blocked;
        (state_ff == LOWERING_STATE) && I_OBSTRUCTION_IN;
    endsequence

    sequence s_gap_then_raise;
        (state_ff == PRESS_TO_RAISE_STATE) && !O_LOWER_CMD_OUT && !O_RAISE_CMD_OUT;
    endsequence

    chk_motor_match: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE4
        (O_RAISE_CMD_OUT == (state_ff == RAISING_STATE))
        && (O_LOWER_CMD_OUT == (state_ff == LOWERING_STATE)))
        else $error("motor command does not match state");

    chk_closed_idle: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE2
        (state_ff == DOOR_CLOSED_STATE) |-> !O_RAISE_CMD_OUT && !O_LOWER_CMD_OUT)
        else $error("motor on while closed");

    chk_release_raise: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE3
        (state_ff == PRESS_TO_RAISE_STATE && !I_DOOR_BUTTON_IN)
        |=> (state_ff == RAISING_STATE) && O_LAMP_OUT)
        else $error("release did not start raising and light");

    chk_up_limit_open: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE5
        (state_ff == RAISING_STATE && I_UP_LIMIT_IN) |=> (state_ff == DOOR_OPEN_STATE)
        ##0 !O_RAISE_CMD_OUT)
        else $error("up limit did not stop raising");

    chk_lower_path: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE6
        (state_ff == DOOR_OPEN_STATE && I_DOOR_BUTTON_IN) ##1 !I_DOOR_BUTTON_IN
        |=> (state_ff == LOWERING_STATE) && O_LAMP_OUT)
        else $error("press-release did not start lowering");

    chk_down_limit: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE7
        (state_ff == LOWERING_STATE && I_DOWN_LIMIT_IN && !I_OBSTRUCTION_IN)
        |=> (state_ff == DOOR_CLOSED_STATE))
        else $error("down limit did not close");

    chk_obstruct_gap: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE8
        s_lowering_blocked |=> s_gap_then_raise)
        else $error("obstruction did not reverse through gap scan");

    chk_obstruct_wins: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE9
        (state_ff == LOWERING_STATE && I_DOWN_LIMIT_IN && I_OBSTRUCTION_IN)
        |=> (state_ff != DOOR_CLOSED_STATE))
        else $error("down limit taken despite obstruction");

    chk_one_state: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE19
        state_ff inside {DOOR_CLOSED_STATE, PRESS_TO_RAISE_STATE, RAISING_STATE,
                         DOOR_OPEN_STATE, PRESS_TO_LOWER_STATE, LOWERING_STATE})
        else $error("illegal door state");
endmodule

// File: verification/gdo_door_model.sv
// gdo_door_model: door travel, both limit switches and the photocell
// assumes registered motor commands on the controller's scan clock
`timescale 1ns/100ps
module gdo_door_model #(
    parameter int unsigned TRAVEL = 6
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_raise,
    input  wire logic i_lower,
    input  wire logic i_object,
    output logic      o_up_limit,
    output logic      o_down_limit,
    output logic      o_obstruction
);
    logic [3:0] pos_ff;
    logic [3:0] nxt_pos;

    always_comb begin
        nxt_pos = pos_ff;
        if (i_raise && pos_ff < 4'(TRAVEL)) begin
            nxt_pos = pos_ff + 4'h1;
        end else if (i_lower && pos_ff > 4'h0) begin
            nxt_pos = pos_ff - 4'h1;
        end
    end

    // door assumed fully down at powerup
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pos_ff <= 4'h0;
        end else begin
            pos_ff <= nxt_pos;
        end
    end

    // switches close only at the ends, never mid-travel
    assign o_down_limit  = (pos_ff == 4'h0);
    assign o_up_limit    = (pos_ff == 4'(TRAVEL));
    // level follows the object for as long as it stays in the path
    assign o_obstruction = i_object;
endmodule

// File: verification/testbench.sv
// testbench: drives the pushbutton and object, scores output changes in order
// assumes the controller answers one scan after each sampled input
`timescale 1ns/100ps
module testbench;
    import gdo_pkg::*;
    localparam int TB_TICK   = 4;
    localparam int TB_PRESET = 5;
    logic       clk = 1'b0;
    logic       rst;
    logic       button;
    logic       object;
    logic       up_lim;
    logic       down_lim;
    logic       obstr;
    logic       raise;
    logic       lower;
    logic       lamp;
    logic       done;
    logic [2:0] exp_q[$];
    logic [2:0] cur;
    logic [2:0] prev;
    logic [2:0] e;
    logic       done_prev;
    int         lamp_cyc;
    int         n_fail = 0;
    int         checks = 0;
    int         seed;

    always #20 clk = ~clk;

    gdo_door_ctrl #(.TICK_LEN(TB_TICK), .PRESET(TB_PRESET)) dut (
        .I_CLK(clk), .I_RESET(rst), .I_DOOR_BUTTON_IN(button),
        .I_UP_LIMIT_IN(up_lim), .I_DOWN_LIMIT_IN(down_lim),
        .I_OBSTRUCTION_IN(obstr), .O_RAISE_CMD_OUT(raise),
        .O_LOWER_CMD_OUT(lower), .O_LAMP_OUT(lamp), .O_LIGHT_TIMER_DONE(done));

    gdo_door_model #(.TRAVEL(6)) mdl (
        .i_clk(clk), .i_reset(rst), .i_raise(raise), .i_lower(lower),
        .i_object(object), .o_up_limit(up_lim), .o_down_limit(down_lim),
        .o_obstruction(obstr));

    // any change of {raise, lower, lamp} must match the oldest note
    always @(negedge clk) begin
        cur = {raise, lower, lamp};
        if (!rst && cur !== prev) begin
            checks++;
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 3'bxxx;
            if (cur !== e) begin
                n_fail++;
                $display("CHECK FAILED raise_lower_lamp expected %b seen %b", e, cur);
            end
            if (prev[0] === 1'b1 && cur[0] === 1'b0) begin
                checks++;
                if (done_prev !== 1'b1) begin
                    n_fail++;
                    $display("CHECK FAILED done_before_lamp_off expected 1 seen %b", done_prev);
                end
                checks++;
                // a re-set while lit must not stretch the lamp time
                if (lamp_cyc != TB_TICK * TB_PRESET + 1) begin
                    n_fail++;
                    $display("CHECK FAILED lamp_on_cycles expected %0d seen %0d",
                             TB_TICK * TB_PRESET + 1, lamp_cyc);
                end
            end
        end
        lamp_cyc = (lamp === 1'b1) ? lamp_cyc + 1 : 0;
        prev = cur;
        done_prev = done;
    end

    function automatic int hold();
        hold = 1 + ($unsigned($random(seed)) % 4);
    endfunction

    // a held button must not move the door twice; release is required
    task automatic press_release();
        @(posedge clk);
        button <= 1'b1;
        repeat (hold()) @(posedge clk);
        button <= 1'b0;
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        checks++;
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("CHECK FAILED pending_changes expected 0 seen %0d", exp_q.size());
        end
    endtask

    // obs_pos below zero lowers all the way; otherwise the object appears one step below obs_pos
    task automatic lower_run(input int obs_pos);
        exp_q.push_back(3'b011);
        exp_q.push_back(3'b001);
        if (obs_pos >= 0) begin
            exp_q.push_back(3'b101);
            exp_q.push_back(3'b001);
        end
        exp_q.push_back(3'b000);
        press_release();
        if (obs_pos >= 0) begin
            do @(negedge clk); while (!(lower === 1'b1 && mdl.pos_ff == 4'(obs_pos)));
            @(posedge clk);
            object <= 1'b1;
            repeat (1 + hold()) @(posedge clk);
            object <= 1'b0;
        end
        drain();
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #240000;
        n_fail++;
        print_verdict();
    end

    initial begin
        seed = 60924;
        rst = 1'b1;
        button = 1'b0;
        object = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        checks++;
        if ({raise, lower, lamp, done} !== 4'h0) begin
            n_fail++;
            $display("CHECK FAILED reset_outputs expected 0000 seen %b",
                     {raise, lower, lamp, done});
        end
        exp_q.push_back(3'b101);
        exp_q.push_back(3'b001);
        exp_q.push_back(3'b000);
        press_release();
        drain();
        lower_run(3);
        lower_run(1);
        lower_run(-1);
        print_verdict();
    end
endmodule
